// ===== design/swtl_map.svh
// Constants of the single-wire token link: timing, flag codes and reset values.
// Assumes a 100 ns system clock; times are in ns and turned into cycles by the user.
`ifndef SWTL_MAP_SVH
`define SWTL_MAP_SVH
`define SWTL_CLK_NS          100
`define SWTL_UART_BIT_NS     4_340
`define SWTL_TOKEN_NS        43_400
`define SWTL_WAKE_LOW_NS     60_000
`define SWTL_SLEEP_GLITCH_NS 15_000
`define SWTL_MAX_ZERO_LOW_NS 8_680
`define SWTL_BIT_WINDOW_NS   13_000
`define SWTL_TURN_NS         20_000
`define SWTL_TIMEOUT_NS      1_000_000
`define SWTL_WATCHDOG_NS     1_300_000_000
`define SWTL_FLAG_CMD        8'h77
`define SWTL_FLAG_XMIT       8'h88
`define SWTL_FLAG_IDLE       8'hBB
`define SWTL_FLAG_SLEEP      8'hCC
`define SWTL_STAT_WAKE       8'h11
`define SWTL_SHORT_GROUP_LEN 8'h04
`define SWTL_CRC_POLY        16'h8005
`define SWTL_CRC_INIT        16'h0000
`define SWTL_FIFO_WIDTH      8
`define SWTL_FIFO_DEPTH      16
`define SWTL_GPIO_RESET      1'b0
`endif

// ===== design/swtl_pkg.sv
// Types of the single-wire token link.
// Assumes nothing beyond a SystemVerilog compiler.
package swtl_pkg;

   typedef enum logic [2:0] {ST_SLEEP, ST_IDLE, ST_FLAG, ST_CMD, ST_TURN, ST_TX} swtl_state_t;

   typedef struct packed {
      logic        sync1;
      logic        sync2;
      logic        line;
      swtl_state_t st;
      logic [9:0]  low_cnt;
      logic        in_tok;
      logic [9:0]  win;
      logic        second;
      logic        bad;
      logic [7:0]  sh;
      logic [2:0]  bcnt;
      logic [7:0]  remain;
      logic        first;
      logic        to_arm;
      logic [23:0] to_cnt;
      logic [31:0] wd_cnt;
      logic [9:0]  tcnt;
      logic [7:0]  txb;
      logic [2:0]  txi;
      logic        from_fifo;
      logic [1:0]  didx;
      logic [7:0]  status;
      logic        oe;
      logic        gpio;
      logic        rx_valid;
      logic [7:0]  rx_data;
      logic        cmd_done;
      logic        flush;
      logic        wipe;
   } swtl_st_t;

endpackage : swtl_pkg

// ===== design/swtl_stream_if.sv
// Carrier between the link and its response FIFO.
// Assumes one clock; the link drives the push side from its own ports.
`timescale 1ns/1ns
interface swtl_stream_if #(parameter int WIDTH = 8);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;
   logic             clear;

   modport fifo (input in_valid, in_data, out_ready, clear,
                 output in_ready, out_valid, out_data);
   modport link (output in_valid, in_data, out_ready, clear,
                 input in_ready, out_valid, out_data);
endinterface : swtl_stream_if

// ===== design/swtl_fifo.sv
// Response FIFO: flip-flop storage, valid and ready on both sides, synchronous clear.
// Assumes DEPTH is a power of two and rst_n is already synchronised.
`timescale 1ns/1ns
module swtl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic   clk,
   input wire logic   rst_n,
   swtl_stream_if.fifo sif
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } swtl_fifo_st_t;

   swtl_fifo_st_t s;
   swtl_fifo_st_t next_s;
   logic          full;
   logic          empty;

   assign full          = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
   assign empty         = (s.wp == s.rp);
   assign sif.in_ready  = !full;
   assign sif.out_valid = !empty;
   assign sif.out_data  = s.mem[s.rp[AW-1:0]];

   always_comb begin
      next_s = s;
      if (sif.clear) begin
         next_s.wp = '0;
         next_s.rp = '0;
      end else begin
         if (sif.in_valid && !full) begin
            next_s.mem[s.wp[AW-1:0]] = sif.in_data;
            next_s.wp = s.wp + 1'b1;
         end
         if (sif.out_ready && !empty) begin
            next_s.rp = s.rp + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule : swtl_fifo

// ===== design/swtl_link.sv
// Device end of the single-wire token link: token decode, flags, groups and replies.
// Assumes the data pin is open drain with a pull-up outside, and that command
// execution, its busy level and its result bytes come from logic on clk.
`timescale 1ns/1ns
`include "swtl_map.svh"
module swtl_link #(
   parameter int unsigned TIMEOUT_NS  = `SWTL_TIMEOUT_NS,
   parameter int unsigned WATCHDOG_NS = `SWTL_WATCHDOG_NS
) (
   input  wire logic  clk,
   input  wire logic  arst_n,
   input  wire logic  sda_in,
   output logic       sda_out,
   output logic       sda_oe,
   input  wire logic  exec_busy,
   input  wire logic  watchdog_en,
   input  wire logic  status_wr,
   input  wire logic [7:0] status_data,
   input  wire logic  resp_valid,
   input  wire logic [7:0] resp_data,
   output logic       resp_ready,
   output logic       rx_valid,
   output logic [7:0] rx_data,
   output logic       cmd_done,
   output logic       idle_flush,
   output logic       sleep_wipe,
   output logic       link_asleep,
   output logic       link_idle,
   input  wire logic  one_wire_mode,
   input  wire logic  gpio_wr,
   input  wire logic  gpio_val,
   output logic       gpio_out,
   output logic       gpio_oe
);
   import swtl_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // A least time rounds up, a longest time rounds down, never below one cycle.
   function automatic int unsigned cyc_up(input int unsigned ns);
      return (ns + `SWTL_CLK_NS - 1) / `SWTL_CLK_NS;
   endfunction : cyc_up

   function automatic int unsigned cyc_dn(input int unsigned ns);
      int unsigned q;
      q = ns / `SWTL_CLK_NS;
      return (q == 0) ? 1 : q;
   endfunction : cyc_dn

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         fb = b[i] ^ r[15];
         r  = {r[14:0], 1'b0};
         if (fb) begin
            r = r ^ `SWTL_CRC_POLY;
         end
      end
      return r;
   endfunction : crc_step

   // Short group sent when no results wait in the FIFO.
   function automatic logic [7:0] short_byte(input logic [1:0] idx, input logic [7:0] stat);
      logic [15:0] crc;
      crc = crc_step(crc_step(`SWTL_CRC_INIT, `SWTL_SHORT_GROUP_LEN), stat);
      unique case (idx)
         2'd0: return `SWTL_SHORT_GROUP_LEN;
         2'd1: return stat;
         2'd2: return crc[7:0];
         2'd3: return crc[15:8];
      endcase
   endfunction : short_byte

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam logic [9:0]  WAKE_CYC  = 10'(cyc_up(`SWTL_WAKE_LOW_NS));
   localparam logic [9:0]  IGN_CYC   = 10'(cyc_up(`SWTL_SLEEP_GLITCH_NS));
   localparam logic [9:0]  MAXZ_CYC  = 10'(cyc_dn(`SWTL_MAX_ZERO_LOW_NS));
   localparam logic [9:0]  WIN_CYC   = 10'(cyc_dn(`SWTL_BIT_WINDOW_NS));
   localparam logic [9:0]  BIT_CYC   = 10'(cyc_dn(`SWTL_UART_BIT_NS));
   localparam logic [9:0]  TOK_CYC   = 10'(cyc_dn(`SWTL_TOKEN_NS));
   localparam logic [9:0]  TURN_CYC  = 10'(cyc_dn(`SWTL_TURN_NS));
   localparam logic [9:0]  Z_ON      = 10'(2 * cyc_dn(`SWTL_UART_BIT_NS));
   localparam logic [9:0]  Z_OFF     = 10'(3 * cyc_dn(`SWTL_UART_BIT_NS));
   localparam logic [23:0] TO_CYC    = 24'(cyc_dn(TIMEOUT_NS));
   localparam logic [31:0] WD_CYC    = 32'(cyc_dn(WATCHDOG_NS));

   // ----------------------------------------------------------------
   // Reset release and response FIFO
   // ----------------------------------------------------------------
   logic [1:0] rst_sync;
   logic       rst_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   swtl_stream_if #(.WIDTH(`SWTL_FIFO_WIDTH)) resp_if ();

   swtl_fifo #(.WIDTH(`SWTL_FIFO_WIDTH), .DEPTH(`SWTL_FIFO_DEPTH)) u_fifo (
      .clk   (clk),
      .rst_n (rst_n),
      .sif   (resp_if.fifo)
   );

   swtl_st_t s;
   swtl_st_t next_s;
   logic     pop;
   logic     clr;

   assign resp_if.in_valid  = resp_valid;
   assign resp_if.in_data   = resp_data;
   assign resp_if.out_ready = pop;
   assign resp_if.clear     = clr;
   assign resp_ready        = resp_if.in_ready;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       fall;
      logic       rise;
      logic       listen;
      logic       data_rx;
      logic       wake_hit;
      logic       illegal;
      logic       bit_evt;
      logic       bitv;
      logic       byte_evt;
      logic [7:0] byte_v;
      logic       sleep_now;
      fall      = 1'b0;
      rise      = 1'b0;
      listen    = 1'b0;
      data_rx   = 1'b0;
      wake_hit  = 1'b0;
      illegal   = 1'b0;
      bit_evt   = 1'b0;
      bitv      = 1'b0;
      byte_evt  = 1'b0;
      byte_v    = 8'h00;
      sleep_now = 1'b0;
      pop       = 1'b0;
      clr       = 1'b0;
      next_s          = s;
      next_s.sync1    = sda_in;
      next_s.sync2    = s.sync1;
      next_s.line     = s.sync2;
      next_s.rx_valid = 1'b0;
      next_s.cmd_done = 1'b0;
      next_s.flush    = 1'b0;
      next_s.wipe     = 1'b0;

      fall = s.line && !s.sync2;
      rise = !s.line && s.sync2;
      if (!s.sync2) begin
         next_s.low_cnt = (s.low_cnt == 10'h3FF) ? s.low_cnt : s.low_cnt + 10'd1;
      end else begin
         next_s.low_cnt = 10'd0;
      end

      // While our own tokens go out, or a command runs, the line is not watched.
      listen   = (s.st != ST_TX) && !exec_busy;
      wake_hit = listen && rise && (s.low_cnt >= WAKE_CYC)
                 && ((s.st != ST_SLEEP) || (s.low_cnt >= IGN_CYC));
      data_rx  = listen && ((s.st == ST_FLAG) || (s.st == ST_CMD));
      illegal  = data_rx && rise && (s.low_cnt > MAXZ_CYC) && (s.low_cnt < WAKE_CYC);

      // Token decode: one low pulse is a one, a second pulse in the window a zero.
      if (data_rx) begin
         if (s.in_tok) begin
            next_s.win = s.win + 10'd1;
            if (fall) begin
               next_s.second = 1'b1;
            end
            if (illegal) begin
               next_s.in_tok = 1'b0;
               next_s.bad    = 1'b1;
            end else if (s.win == WIN_CYC - 10'd1) begin
               next_s.in_tok = 1'b0;
               bit_evt       = 1'b1;
               bitv          = !s.second;
            end
         end else if (fall) begin
            next_s.in_tok = 1'b1;
            next_s.win    = 10'd0;
            next_s.second = 1'b0;
            if (!s.to_arm) begin
               next_s.to_arm = 1'b1;
               next_s.to_cnt = 24'd0;
            end
         end
      end else begin
         next_s.in_tok = 1'b0;
      end

      if (bit_evt) begin
         if (!s.bad) begin
            next_s.to_cnt = 24'd0;
         end
         next_s.sh   = {bitv, s.sh[7:1]};
         next_s.bcnt = s.bcnt + 3'd1;
         if (s.bcnt == 3'd7) begin
            byte_evt = 1'b1;
            byte_v   = {bitv, s.sh[7:1]};
         end
      end

      // Inter-token timeout; it never runs while a command executes.
      if (s.to_arm && !exec_busy) begin
         if (!bit_evt || s.bad) begin
            next_s.to_cnt = s.to_cnt + 24'd1;
         end
         if (s.to_cnt >= TO_CYC - 24'd1) begin
            sleep_now = 1'b1;
         end
      end

      // Watchdog counts from wake, but not in idle or sleep.
      if (watchdog_en && (s.st != ST_SLEEP) && (s.st != ST_IDLE)) begin
         next_s.wd_cnt = s.wd_cnt + 32'd1;
         if (s.wd_cnt >= WD_CYC - 32'd1) begin
            sleep_now = 1'b1;
         end
      end

      if (status_wr) begin
         next_s.status = status_data;
      end

      unique case (s.st)
         ST_SLEEP, ST_IDLE: begin
         end
         ST_FLAG: begin
            if (byte_evt) begin
               next_s.to_arm = 1'b0;
               case (byte_v)
                  `SWTL_FLAG_CMD: begin
                     next_s.st     = ST_CMD;
                     next_s.first  = 1'b1;
                     next_s.to_arm = 1'b1;
                  end
                  `SWTL_FLAG_XMIT: begin
                     next_s.st   = ST_TURN;
                     next_s.tcnt = 10'd0;
                  end
                  `SWTL_FLAG_IDLE: begin
                     next_s.st    = ST_IDLE;
                     next_s.flush = 1'b1;
                     clr          = 1'b1;
                  end
                  `SWTL_FLAG_SLEEP: begin
                     sleep_now = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_CMD: begin
            if (byte_evt) begin
               next_s.rx_valid = 1'b1;
               next_s.rx_data  = byte_v;
               next_s.first    = 1'b0;
               if (s.first) begin
                  next_s.remain = byte_v - 8'd1;
               end else begin
                  next_s.remain = s.remain - 8'd1;
               end
               if ((s.first && byte_v <= 8'd1) || (!s.first && s.remain == 8'd1)) begin
                  next_s.cmd_done = 1'b1;
                  next_s.st       = ST_FLAG;
                  next_s.to_arm   = 1'b0;
               end
            end
         end
         ST_TURN: begin
            next_s.tcnt = s.tcnt + 10'd1;
            if (s.tcnt == TURN_CYC - 10'd1) begin
               next_s.st   = ST_TX;
               next_s.tcnt = 10'd0;
               next_s.txi  = 3'd0;
               if (resp_if.out_valid) begin
                  next_s.txb       = resp_if.out_data;
                  next_s.from_fifo = 1'b1;
                  pop              = 1'b1;
               end else begin
                  next_s.txb       = short_byte(2'd0, s.status);
                  next_s.from_fifo = 1'b0;
                  next_s.didx      = 2'd0;
               end
            end
         end
         ST_TX: begin
            // Same waveform as the host: a one is one low bit, a zero adds a second.
            next_s.oe   = (s.tcnt < BIT_CYC) ||
                          (!s.txb[s.txi] && (s.tcnt >= Z_ON) && (s.tcnt < Z_OFF));
            next_s.tcnt = s.tcnt + 10'd1;
            if (s.tcnt == TOK_CYC - 10'd1) begin
               next_s.tcnt = 10'd0;
               next_s.txi  = s.txi + 3'd1;
               next_s.oe   = 1'b0;
               if (s.txi == 3'd7) begin
                  if (s.from_fifo && resp_if.out_valid) begin
                     next_s.txb = resp_if.out_data;
                     pop        = 1'b1;
                  end else if (!s.from_fifo && s.didx != 2'd3) begin
                     next_s.didx = s.didx + 2'd1;
                     next_s.txb  = short_byte(s.didx + 2'd1, s.status);
                  end else begin
                     next_s.st = ST_FLAG;
                  end
               end
            end
         end
      endcase

      if (sleep_now) begin
         next_s.st     = ST_SLEEP;
         next_s.wipe   = 1'b1;
         next_s.oe     = 1'b0;
         next_s.to_arm = 1'b0;
         next_s.bad    = 1'b0;
         next_s.bcnt   = 3'd0;
         next_s.in_tok = 1'b0;
         clr           = 1'b1;
      end

      // Wake beats everything but a sleep_wipe pulse from the same cycle: out of sleep or idle, or an interface reset.
      if (wake_hit) begin
         next_s.st     = ST_FLAG;
         next_s.status = `SWTL_STAT_WAKE;
         next_s.wd_cnt = 32'd0;
         next_s.to_arm = 1'b0;
         next_s.bad    = 1'b0;
         next_s.bcnt   = 3'd0;
         next_s.in_tok = 1'b0;
         next_s.oe     = 1'b0;
         if ((s.st != ST_SLEEP) && (s.st != ST_IDLE)) begin
            clr = 1'b1;
         end
      end

      if (!one_wire_mode) begin
         next_s.gpio = `SWTL_GPIO_RESET;
      end else if (gpio_wr) begin
         next_s.gpio = gpio_val;
      end
   end

   // All resets to zero and ST_SLEEP; line samples start high, so no false edge follows.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s       <= '0;
         s.sync1 <= 1'b1;
         s.sync2 <= 1'b1;
         s.line  <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign sda_out     = 1'b0;
   assign sda_oe      = s.oe;
   assign rx_valid    = s.rx_valid;
   assign rx_data     = s.rx_data;
   assign cmd_done    = s.cmd_done;
   assign idle_flush  = s.flush;
   assign sleep_wipe  = s.wipe;
   assign link_asleep = (s.st == ST_SLEEP);
   assign link_idle   = (s.st == ST_IDLE);
   assign gpio_out    = s.gpio;
   assign gpio_oe     = one_wire_mode;
endmodule : swtl_link

// ===== verification/swtl_link_asserts.sv
// Port assertions for swtl_link.
// Assumes it is bound to swtl_link and sees only that module's ports.
`timescale 1ns/1ns
module swtl_link_asserts (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sda_oe,
   input wire logic exec_busy,
   input wire logic rx_valid,
   input wire logic cmd_done,
   input wire logic idle_flush,
   input wire logic sleep_wipe,
   input wire logic link_asleep,
   input wire logic link_idle,
   input wire logic one_wire_mode,
   input wire logic gpio_out,
   input wire logic gpio_oe
);
   logic [7:0] n;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Counts the low part of a device token, so a wrong width shows at release.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) n <= 8'h00;
      else n <= sda_oe ? n + 8'h01 : 8'h00;
   end
   chk_tok_width: assert property ($fell(sda_oe) |-> n == 8'h2B)
      else $error("token width");
   chk_sleep_quiet: assert property (link_asleep |-> !sda_oe && !rx_valid)
      else $error("asleep active");
   chk_idle_quiet: assert property (link_idle |-> !sda_oe && !rx_valid)
      else $error("idle active");
   chk_flush_idle: assert property (idle_flush |-> ##[0:2] link_idle)
      else $error("flush without idle");
   chk_wipe_sleep: assert property (sleep_wipe |-> ##[0:2] link_asleep)
      else $error("wipe without sleep");
   chk_wipe_pulse: assert property (sleep_wipe |=> !sleep_wipe)
      else $error("wipe too long");
   chk_done_byte: assert property (cmd_done |-> rx_valid)
      else $error("done without byte");
   chk_busy_quiet: assert property (exec_busy [*3] |-> !rx_valid && !sleep_wipe)
      else $error("busy not quiet");
   chk_gpio_mode: assert property (!one_wire_mode |-> ##[0:1] !gpio_oe && !gpio_out)
      else $error("gpio in bus mode");
   cover property (cmd_done);
   cover property (sleep_wipe);
   cover property ($rose(sda_oe));
endmodule : swtl_link_asserts

bind swtl_link swtl_link_asserts u_chk (.clk(clk), .arst_n(arst_n), .sda_oe(sda_oe),
   .exec_busy(exec_busy), .rx_valid(rx_valid), .cmd_done(cmd_done),
   .idle_flush(idle_flush), .sleep_wipe(sleep_wipe), .link_asleep(link_asleep),
   .link_idle(link_idle), .one_wire_mode(one_wire_mode), .gpio_out(gpio_out),
   .gpio_oe(gpio_oe));

// ===== verification/swtl_host_model.sv
// Host end of the link: sends wake and bit tokens, reads device tokens.
// Assumes a pull-up on the line; host_low high pulls the line down.
`timescale 1ns/1ns
module swtl_host_model #(parameter int PER = 180) (
   input wire logic clk,
   input wire logic line,
   output logic     host_low
);
   initial host_low = 1'b0;
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc
   // Short bit period keeps a scaled timeout usable; the device still sees legal spacing.
   task automatic send_bit(input logic b);
      host_low = 1'b1;
      cyc(43);
      host_low = 1'b0;
      if (!b) begin
         cyc(43);
         host_low = 1'b1;
         cyc(43);
         host_low = 1'b0;
      end
      cyc(b ? PER - 43 : PER - 129);
   endtask : send_bit
   task automatic send_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) send_bit(v[i]);
   endtask : send_byte
   task automatic send_wake;
      host_low = 1'b1;
      cyc(700);
      host_low = 1'b0;
      cyc(100);
   endtask : send_wake
   task automatic recv_byte(output logic [7:0] d, output int wt, output logic ok);
      int k;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         k = 0;
         while (line && k < 1000) begin
            cyc(1);
            k++;
         end
         if (i == 0) wt = k;
         if (k >= 1000) ok = 1'b0;
         cyc(60);
         k = 0;
         while (line && k < 80) begin
            cyc(1);
            k++;
         end
         d[i] = line;
         if (!d[i]) cyc(50);
      end
   endtask : recv_byte
endmodule : swtl_host_model

// ===== verification/tb.sv
// Self-checking bench for swtl_link with a host model on the line.
// Assumes the line has a pull-up and nothing else drives it.
`timescale 1ns/1ns
module tb;
   logic       clk, arst_n, busy, gwr, gval, owm, rvld, host_low, ok;
   logic       oe, rdy, rxv, done, flush, wipe, asleep, idle, gout, goe, wden, swr, sdo;
   logic       s_oe, s_fl, s_wp, s_dn;
   logic [7:0] rdat, rxd, d, sdat;
   logic [7:0] rxq[$];
   int         num_errors = 0, cmp_count = 0, wt;
   wire        line = !(host_low || (oe && !sdo));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   swtl_link #(.TIMEOUT_NS(40_000), .WATCHDOG_NS(100_000)) u_dut (.clk(clk),
      .arst_n(arst_n), .sda_in(line), .sda_out(sdo), .sda_oe(oe), .exec_busy(busy),
      .watchdog_en(wden), .status_wr(swr), .status_data(sdat), .resp_valid(rvld),
      .resp_data(rdat), .resp_ready(rdy), .rx_valid(rxv), .rx_data(rxd),
      .cmd_done(done), .idle_flush(flush), .sleep_wipe(wipe), .link_asleep(asleep),
      .link_idle(idle), .one_wire_mode(owm), .gpio_wr(gwr), .gpio_val(gval),
      .gpio_out(gout), .gpio_oe(goe));
   swtl_host_model u_host (.clk(clk), .line(line), .host_low(host_low));
   always @(posedge clk) begin
      s_oe <= s_oe | oe;
      s_fl <= s_fl | flush;
      s_wp <= s_wp | wipe;
      s_dn <= s_dn | done;
      if (rxv) rxq.push_back(rxd);
   end
   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic get(input string nm, input logic [7:0] e);
      u_host.recv_byte(d, wt, ok);
      chk(nm, e, d);
      if (!ok) begin
         num_errors++;
         test_done();
      end
   endtask : get
   function automatic logic [15:0] crc16(input logic [15:0] m);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 0; i < 16; i++) c = {c[14:0], 1'b0} ^ ((m[i] ^ c[15]) ? 16'h8005 : 16'h0000);
      return c;
   endfunction : crc16
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_wake;
      chk("gpio reset", 0, gout);
      s_oe = 1'b0;
      u_host.send_byte(8'h88);
      u_host.cyc(600);
      chk("oe asleep", 0, s_oe);
      // A stored status must give way to the wake status checked in the reply test.
      sdat = 8'h5C;
      swr = 1'b1;
      u_host.cyc(1);
      swr = 1'b0;
      u_host.send_wake();
      chk("awake", 0, asleep);
      $display("wake test done");
   endtask : t_wake
   task automatic t_reply;
      logic [15:0] c;
      c = crc16({8'h11, 8'h04});
      u_host.send_byte(8'h88);
      get("count", 8'h04);
      chk("turnaround", 1, wt <= 250);
      get("status", 8'h11);
      get("crc lo", c[7:0]);
      get("crc hi", c[15:8]);
      u_host.cyc(400);
      $display("reply test done");
   endtask : t_reply
   task automatic t_fifo;
      rvld = 1'b1;
      for (int i = 0; i < 16; i++) begin
         rdat = 8'(i * 17);
         u_host.cyc(1);
      end
      chk("full", 0, rdy);
      rvld = 1'b0;
      u_host.send_byte(8'h88);
      for (int i = 0; i < 16; i++) get("fifo", 8'(i * 17));
      u_host.cyc(400);
      $display("fifo test done");
   endtask : t_fifo
   task automatic t_cmd;
      rxq.delete();
      s_dn = 1'b0;
      u_host.send_byte(8'h77);
      u_host.send_byte(8'h03);
      u_host.send_byte(8'hA5);
      u_host.send_byte(8'h5A);
      u_host.cyc(200);
      chk("rx count", 3, 16'(rxq.size()));
      chk("rx mid", 8'hA5, rxq[1]);
      chk("rx last", 8'h5A, rxq[2]);
      chk("done", 1, s_dn);
      chk("cmd awake", 0, asleep);
      $display("command test done");
   endtask : t_cmd
   task automatic t_busy;
      busy = 1'b1;
      s_wp = 1'b0;
      u_host.send_byte(8'hCC);
      u_host.cyc(600);
      busy = 1'b0;
      chk("busy wipe", 0, s_wp);
      $display("busy test done");
   endtask : t_busy
   task automatic t_idle;
      s_fl = 1'b0;
      u_host.send_byte(8'hBB);
      u_host.cyc(10);
      chk("flush", 1, s_fl);
      chk("idle", 1, idle);
      s_oe = 1'b0;
      u_host.send_byte(8'h88);
      u_host.cyc(600);
      chk("idle oe", 0, s_oe);
      u_host.send_wake();
      chk("left idle", 0, idle);
      $display("idle test done");
   endtask : t_idle
   task automatic t_sleep;
      s_wp = 1'b0;
      u_host.send_byte(8'hCC);
      u_host.cyc(10);
      chk("sleep", 3, {s_wp, asleep});
      u_host.send_wake();
      s_wp = 1'b0;
      u_host.send_bit(1'b1);
      u_host.send_bit(1'b0);
      u_host.cyc(500);
      chk("timeout", 3, {s_wp, asleep});
      $display("sleep test done");
   endtask : t_sleep
   task automatic t_dog;
      u_host.send_wake();
      s_wp = 1'b0;
      wden = 1'b1;
      u_host.cyc(900);
      chk("dog early", 0, asleep);
      u_host.cyc(200);
      chk("dog sleep", 3, {s_wp, asleep});
      $display("watchdog test done");
   endtask : t_dog
   task automatic t_gpio;
      {gval, gwr} = 2'h3;
      u_host.cyc(1);
      gwr = 1'b0;
      u_host.cyc(2);
      chk("gpio set", 3, {goe, gout});
      owm = 1'b0;
      u_host.cyc(2);
      chk("gpio off", 0, {goe, gout});
      owm = 1'b1;
      $display("gpio test done");
   endtask : t_gpio
   initial begin
      {busy, gwr, gval, rvld, s_oe, s_fl, s_wp, s_dn} = 8'h00;
      {owm, arst_n, rdat} = 10'h200;
      {wden, swr, sdat} = 10'h000;
      repeat (3) @(posedge clk);
      #1 arst_n = 1'b1;
      u_host.cyc(3);
      t_wake();
      t_reply();
      t_fifo();
      t_cmd();
      t_busy();
      t_idle();
      t_gpio();
      t_sleep();
      t_dog();
      test_done();
   end
endmodule : tb
